// *** alu_pkg.sv ***
// Purpose: Shared types and constants for the arithmetic and logic datapath
// Assumes: One 200 MHz core clock, synchronous active-high reset
// Notes:   Cycle figures are the listed flash-fetch clock counts
package alu_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned BYTE_W         = 8;
    localparam int unsigned WORD_W         = 16;
    localparam int unsigned HALF_BIT       = 3;
    localparam int unsigned HALF_BIT_WIDE  = 11;
    localparam logic [7:0]  ZERO_BYTE      = 8'h00;
    localparam logic [15:0] ZERO_WORD      = 16'h0000;
    // Cycle counts (flash fetch)
    localparam logic [3:0]  CLK_BYTE_BASE  = 4'h1;
    localparam logic [3:0]  CLK_WORD_BASE  = 4'h2;
    localparam logic [3:0]  CLK_SADDR_IMM  = 4'h2;
    localparam logic [3:0]  CLK_SEG_EXTRA  = 4'h1;
    localparam logic [3:0]  CLK_DATA_FLASH = 4'h3;
    // RAM fetch worst case: factor times listed count plus extra
    localparam logic [3:0]  RAM_FETCH_MUL  = 4'h4;
    localparam logic [5:0]  RAM_FETCH_ADD  = 6'h06;

    typedef enum logic [3:0] {
        OP_SUM            = 4'b0000,
        OP_SUM_WITH_CARRY = 4'b0001,
        OP_MINUS          = 4'b0010,
        OP_MINUS_BORROW   = 4'b0011,
        OP_AND            = 4'b0100,
        OP_OR             = 4'b0101,
        OP_XOR            = 4'b0110,
        OP_COMPARE        = 4'b0111,
        OP_ZERO_TEST      = 4'b1000,
        OP_INDEX_COMPARE  = 4'b1001,
        OP_WIDE_SUM       = 4'b1010,
        OP_WIDE_MINUS     = 4'b1011
    } alu_op_t;

    typedef enum logic [2:0] {
        FORM_IMM   = 3'b000,
        FORM_REG   = 3'b001,
        FORM_DIR   = 3'b010,
        FORM_SADDR = 3'b011,
        FORM_IND   = 3'b100,
        FORM_SIMM  = 3'b101
    } form_t;

    typedef struct packed {
        alu_op_t     op;
        form_t       form;
        logic        seg_prefix;
        logic        from_flash;
        logic        fetch_ram;
        logic [15:0] opa;
        logic [15:0] opb;
    } alu_req_t;

    typedef struct packed {
        logic [15:0] result;
        logic        write_back;
        logic        zero_flag;
        logic        half_carry_flag;
        logic        carry_flag;
        logic [7:0]  cycles;
    } alu_rsp_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } alu_state_t;

    typedef struct packed {
        alu_state_t  st;
        alu_rsp_t    rsp;
        logic        zero_flag;
        logic        half_carry_flag;
        logic        carry_flag;
        logic [7:0]  remain;
        logic        done;
    } alu_regs_t;
endpackage : alu_pkg

// *** arith_logic_unit.sv ***
// Purpose: 8/16-bit arithmetic and logic datapath with flag and cycle cost
// Assumes: Sequencer supplies operands already fetched; holds req until taken
// Notes:   The flags live here; result is handed back for write to destination
`timescale 1ns/1ps
// Operation
// - Sum with carry adds both operands and carry; 8-bit result; all three flags updated.
// - Subtract source from destination, store difference, update flags; carry is the borrow.
// - Subtract with borrow also subtracts carry; store result; update all three flags.
// - AND stores the AND; only Z changes.
// - OR stores inclusive OR in every form; only Z changes.
// - XOR stores exclusive OR in every form; only Z changes.
// - Compare subtracts, discards difference, updates only zero, half carry and carry.
// - Zero test sets Z from value, clears AC and CY.
// - Index compare X against pointer byte; discard; all flags; prefixed form 2 clocks.
// - Wide sum adds word to wide accumulator, all flags, 2 clocks register form.
// - Wide minus subtracts word from wide accumulator, stores, all flags.
// - Operand read from code flash takes the longer cycle count.
// - RAM fetch costs at most four times listed clocks plus six.
// - Segment prefix adds one clock over the unprefixed form.
module arith_logic_unit (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire logic              req_valid_i,
    input  alu_pkg::alu_req_t      req_i,
    output logic                   req_ready_o,
    output logic                   done_o,
    output alu_pkg::alu_rsp_t      rsp_o,
    output logic                   zero_flag_o,
    output logic                   half_carry_flag_o,
    output logic                   carry_flag_o
);
    import alu_pkg::*;

    alu_regs_t s_q;
    alu_regs_t s_d;

    function automatic logic is_wide(input alu_op_t op);
        is_wide = (op == OP_WIDE_SUM) || (op == OP_WIDE_MINUS);
    endfunction : is_wide

    function automatic logic [7:0] cost(input alu_req_t r);
        logic [7:0] c;
        c = {4'h0, is_wide(r.op) ? CLK_WORD_BASE : CLK_BYTE_BASE};
        if (r.form == FORM_SIMM && !(r.op == OP_COMPARE))
            c = {4'h0, CLK_SADDR_IMM};
        if (r.seg_prefix)
            c = c + {4'h0, CLK_SEG_EXTRA};
        if (r.from_flash)
            c = c + {4'h0, CLK_DATA_FLASH};
        if (r.fetch_ram)
            c = 8'(c * {4'h0, RAM_FETCH_MUL}) + {2'h0, RAM_FETCH_ADD};
        cost = c;
    endfunction : cost

    logic [8:0]  s8;
    logic [4:0]  h8;
    logic [16:0] s16;
    logic        cin;
    logic        sub;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        cin = 1'b0;
        sub = 1'b0;
        s8 = '0;
        h8 = '0;
        s16 = '0;
        unique case (s_q.st)
            ST_IDLE: begin
                if (req_valid_i) begin
                    unique case (req_i.op)
                        OP_SUM_WITH_CARRY: cin = s_q.carry_flag;
                        OP_MINUS_BORROW:   cin = s_q.carry_flag;
                        default:           cin = 1'b0;
                    endcase
                    sub = req_i.op inside {OP_MINUS, OP_MINUS_BORROW, OP_COMPARE,
                                           OP_INDEX_COMPARE, OP_WIDE_MINUS};
                    if (sub) begin
                        s8  = {1'b0, req_i.opa[7:0]} - {1'b0, req_i.opb[7:0]} - {8'h00, cin};
                        h8  = {1'b0, req_i.opa[3:0]} - {1'b0, req_i.opb[3:0]} - {4'h0, cin};
                        s16 = {1'b0, req_i.opa} - {1'b0, req_i.opb};
                    end else begin
                        s8  = {1'b0, req_i.opa[7:0]} + {1'b0, req_i.opb[7:0]} + {8'h00, cin};
                        h8  = {1'b0, req_i.opa[3:0]} + {1'b0, req_i.opb[3:0]} + {4'h0, cin};
                        s16 = {1'b0, req_i.opa} + {1'b0, req_i.opb};
                    end
                    s_d.rsp.write_back = 1'b1;
                    s_d.rsp.result = {8'h00, s8[7:0]};
                    unique case (req_i.op)
                        OP_SUM, OP_SUM_WITH_CARRY, OP_MINUS, OP_MINUS_BORROW: begin
                            s_d.zero_flag = (s8[7:0] == ZERO_BYTE);
                            s_d.half_carry_flag = h8[4];
                            s_d.carry_flag = s8[8];
                        end
                        OP_AND: begin
                            s_d.rsp.result = {8'h00, req_i.opa[7:0] & req_i.opb[7:0]};
                            s_d.zero_flag = ((req_i.opa[7:0] & req_i.opb[7:0]) == ZERO_BYTE);
                        end
                        OP_OR: begin
                            s_d.rsp.result = {8'h00, req_i.opa[7:0] | req_i.opb[7:0]};
                            s_d.zero_flag = ((req_i.opa[7:0] | req_i.opb[7:0]) == ZERO_BYTE);
                        end
                        OP_XOR: begin
                            s_d.rsp.result = {8'h00, req_i.opa[7:0] ^ req_i.opb[7:0]};
                            s_d.zero_flag = ((req_i.opa[7:0] ^ req_i.opb[7:0]) == ZERO_BYTE);
                        end
                        OP_COMPARE, OP_INDEX_COMPARE: begin
                            s_d.rsp.write_back = 1'b0;
                            s_d.zero_flag = (s8[7:0] == ZERO_BYTE);
                            s_d.half_carry_flag = h8[4];
                            s_d.carry_flag = s8[8];
                        end
                        OP_ZERO_TEST: begin
                            s_d.rsp.write_back = 1'b0;
                            s_d.zero_flag = (req_i.opa[7:0] == ZERO_BYTE);
                            s_d.half_carry_flag = 1'b0;
                            s_d.carry_flag = 1'b0;
                        end
                        OP_WIDE_SUM, OP_WIDE_MINUS: begin
                            s_d.rsp.result = s16[15:0];
                            s_d.zero_flag = (s16[15:0] == ZERO_WORD);
                            // Half carry comes from bit 3 at every width; wide ops have no carry-in
                            s_d.half_carry_flag = h8[4];
                            s_d.carry_flag = s16[16];
                        end
                        default: s_d.rsp.write_back = 1'b0;
                    endcase
                    s_d.rsp.cycles = cost(req_i);
                    s_d.remain = cost(req_i) - 8'h01;
                    if (s_d.remain == 8'h00) begin
                        s_d.done = 1'b1;
                    end else begin
                        s_d.st = ST_BUSY;
                    end
                end
            end
            ST_BUSY: begin
                s_d.remain = s_q.remain - 8'h01;
                if (s_q.remain == 8'h01) begin
                    s_d.done = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
        endcase
        s_d.rsp.zero_flag = s_d.zero_flag;
        s_d.rsp.half_carry_flag = s_d.half_carry_flag;
        s_d.rsp.carry_flag = s_d.carry_flag;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign req_ready_o       = (s_q.st == ST_IDLE) && !s_q.done;
    assign done_o            = s_q.done;
    assign rsp_o             = s_q.rsp;
    assign zero_flag_o       = s_q.zero_flag;
    assign half_carry_flag_o = s_q.half_carry_flag;
    assign carry_flag_o      = s_q.carry_flag;

    logic take;
    assign take = req_valid_i && (s_q.st == ST_IDLE);

    property p_adc;
        @(posedge sys_clk_i) disable iff (rst_i)
        take && req_i.op == OP_SUM_WITH_CARRY |=> s_q.rsp.result[7:0] ==
            8'($past(req_i.opa[7:0]) + $past(req_i.opb[7:0]) + {7'h00, $past(s_q.carry_flag)});
    endproperty
    a_adc: assert property (p_adc) else $error("sum with carry wrong");

    property p_sub;
        @(posedge sys_clk_i) disable iff (rst_i)
        take && req_i.op == OP_MINUS |=> carry_flag_o == ($past(req_i.opa[7:0]) < $past(req_i.opb[7:0]));
    endproperty
    a_sub: assert property (p_sub) else $error("borrow wrong");

    property p_sbb;
        @(posedge sys_clk_i) disable iff (rst_i)
        take && req_i.op == OP_MINUS_BORROW |=> s_q.rsp.result[7:0] ==
            8'($past(req_i.opa[7:0]) - $past(req_i.opb[7:0]) - {7'h00, $past(s_q.carry_flag)});
    endproperty
    a_sbb: assert property (p_sbb) else $error("minus with borrow wrong");

    property p_logic_keep;
        @(posedge sys_clk_i) disable iff (rst_i)
        take && req_i.op inside {OP_AND, OP_OR, OP_XOR} |=> $stable(carry_flag_o) && $stable(half_carry_flag_o);
    endproperty
    a_logic_keep: assert property (p_logic_keep) else $error("logic op touched carry");

    property p_cmp;
        @(posedge sys_clk_i) disable iff (rst_i)
        take && req_i.op inside {OP_COMPARE, OP_INDEX_COMPARE} |=> !rsp_o.write_back;
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare wrote back");

    property p_zero;
        @(posedge sys_clk_i) disable iff (rst_i)
        take && req_i.op == OP_ZERO_TEST |=> !carry_flag_o && !half_carry_flag_o
            && zero_flag_o == ($past(req_i.opa[7:0]) == ZERO_BYTE);
    endproperty
    a_zero: assert property (p_zero) else $error("zero test flags wrong");

    property p_wide_reg;
        @(posedge sys_clk_i) disable iff (rst_i)
        take && req_i.op == OP_WIDE_SUM && req_i.form == FORM_REG && !req_i.seg_prefix
            && !req_i.from_flash && !req_i.fetch_ram |=> !done_o ##1 done_o;
    endproperty
    a_wide_reg: assert property (p_wide_reg) else $error("wide sum not 2 clocks");

    property p_seg;
        @(posedge sys_clk_i) disable iff (rst_i)
        take && !is_wide(req_i.op) && req_i.form != FORM_SIMM && req_i.seg_prefix
            && !req_i.from_flash && !req_i.fetch_ram |=> rsp_o.cycles == 8'h02;
    endproperty
    a_seg: assert property (p_seg) else $error("segment prefix cost wrong");

    property p_flash;
        @(posedge sys_clk_i) disable iff (rst_i)
        take && !is_wide(req_i.op) && req_i.form == FORM_DIR && !req_i.seg_prefix
            && req_i.from_flash && !req_i.fetch_ram |=> rsp_o.cycles == 8'h04;
    endproperty
    a_flash: assert property (p_flash) else $error("flash operand cost wrong");
endmodule : arith_logic_unit

// *** seq_model.sv ***
// Purpose: Sequencer model that hands one request to the datapath and holds it until taken
// Assumes: Single core clock, synchronous active-high reset
// Notes:   Released request fields are inverted so a stale value never passes as current
`timescale 1ns/1ps
module seq_model (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    input  wire logic         go_i,
    input  alu_pkg::alu_req_t cmd_i,
    input  wire logic         ready_i,
    output logic              valid_o,
    output alu_pkg::alu_req_t req_o,
    output logic              taken_o
);
    import alu_pkg::*;
    assign taken_o = valid_o && ready_i;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            req_o   <= '0;
        end else if (taken_o) begin
            valid_o <= 1'b0;
            req_o   <= ~req_o;
        end else if (go_i) begin
            valid_o <= 1'b1;
            req_o   <= cmd_i;
        end
    end
endmodule : seq_model

// *** arith_logic_unit_tb.sv ***
// Purpose: Self-checking bench for the arithmetic and logic datapath
// Assumes: 200 MHz clock, reset held 20 cycles, one request at a time
// Notes:   Flags are tracked here so carry-in and kept flags are predicted
`timescale 1ns/1ps
module arith_logic_unit_tb;
    import alu_pkg::*;
    logic     sys_clk_i   = 1'b0;
    logic     rst_i       = 1'b1;
    logic     go          = 1'b0;
    alu_req_t cmd         = '0;
    alu_req_t req;
    alu_rsp_t rsp;
    logic     valid, ready, done, zf, hf, cf, taken;
    logic     ez          = 1'b0;
    logic     eh          = 1'b0;
    logic     ec          = 1'b0;
    int       fail_count  = 0;
    int       checks_done = 0;
    int       cyc_count   = 0;

    always #2.5 sys_clk_i = ~sys_clk_i;

    seq_model seq_model_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .go_i(go), .cmd_i(cmd),
        .ready_i(ready), .valid_o(valid), .req_o(req), .taken_o(taken));
    arith_logic_unit arith_logic_unit_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(valid),
        .req_i(req), .req_ready_o(ready), .done_o(done), .rsp_o(rsp), .zero_flag_o(zf),
        .half_carry_flag_o(hf), .carry_flag_o(cf));

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    always @(posedge sys_clk_i) begin
        cyc_count++;
        if (cyc_count == 40000) begin
            fail_count++;
            $display("MISMATCH at %0t: run did not finish", $time);
            end_of_test();
        end
    end

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_val

    task automatic check_cyc(input int got, input logic [7:0] exp);
        checks_done++;
        if (got != int'(exp)) begin
            fail_count++;
            $display("MISMATCH at %0t: cost %0d cycles expected %0d", $time, got, exp);
        end
    endtask : check_cyc

    function automatic alu_rsp_t expect_rsp(input alu_req_t r);
        alu_rsp_t    e;
        logic        wide, sub, cin;
        logic [16:0] am, bm, hm, full, hs;
        logic [7:0]  n;
        wide = r.op inside {OP_WIDE_SUM, OP_WIDE_MINUS};
        sub  = r.op inside {OP_MINUS, OP_MINUS_BORROW, OP_COMPARE, OP_INDEX_COMPARE, OP_WIDE_MINUS};
        cin  = (r.op inside {OP_SUM_WITH_CARRY, OP_MINUS_BORROW}) ? ec : 1'b0;
        am   = wide ? {1'b0, r.opa} : {9'h000, r.opa[7:0]};
        bm   = wide ? {1'b0, r.opb} : {9'h000, r.opb[7:0]};
        hm   = 17'h0000F;
        full = sub ? am - bm - 17'(cin) : am + bm + 17'(cin);
        hs   = sub ? (am & hm) - (bm & hm) - 17'(cin) : (am & hm) + (bm & hm) + 17'(cin);
        e = '0;
        e.result          = wide ? full[15:0] : {8'h00, full[7:0]};
        e.carry_flag      = wide ? full[16] : full[8];
        e.half_carry_flag = hs[4];
        case (r.op)
            OP_AND:       e.result = {8'h00, r.opa[7:0] & r.opb[7:0]};
            OP_OR:        e.result = {8'h00, r.opa[7:0] | r.opb[7:0]};
            OP_XOR:       e.result = {8'h00, r.opa[7:0] ^ r.opb[7:0]};
            OP_ZERO_TEST: begin
                e.result          = {8'h00, r.opa[7:0]};
                e.half_carry_flag = 1'b0;
                e.carry_flag      = 1'b0;
            end
            default: ;
        endcase
        if (r.op inside {OP_AND, OP_OR, OP_XOR}) begin
            e.half_carry_flag = eh;
            e.carry_flag      = ec;
        end
        e.zero_flag  = wide ? (e.result == 16'h0000) : (e.result[7:0] == 8'h00);
        e.write_back = !(r.op inside {OP_COMPARE, OP_ZERO_TEST, OP_INDEX_COMPARE});
        n = (wide || (r.form == FORM_SIMM && e.write_back)) ? 8'h02 : 8'h01;
        n = n + {7'h00, r.seg_prefix} + (r.from_flash ? 8'h03 : 8'h00);
        e.cycles = r.fetch_ram ? 8'h04 * n + 8'h06 : n;
        return e;
    endfunction : expect_rsp

    function automatic alu_req_t mk(input alu_op_t op, input form_t f, input logic [15:0] a,
                                    input logic [15:0] b, input logic [2:0] mods);
        alu_req_t r;
        r = '{op, f, mods[2], mods[1], mods[0], a, b};
        return r;
    endfunction : mk

    task automatic run_op(input alu_req_t r);
        alu_rsp_t e;
        int       n;
        e = expect_rsp(r);
        @(posedge sys_clk_i);
        go  <= 1'b1;
        cmd <= r;
        @(posedge sys_clk_i);
        go <= 1'b0;
        n  = 0;
        @(negedge sys_clk_i);
        while (taken !== 1'b1 && n < 20) begin
            @(negedge sys_clk_i);
            n++;
        end
        @(posedge sys_clk_i);
        n = 1;
        #1;
        while (done !== 1'b1 && n < 80) begin
            @(posedge sys_clk_i);
            n++;
            #1;
        end
        check_cyc(n, e.cycles);
        check_val({8'h00, rsp.cycles}, {8'h00, e.cycles}, "cycles");
        check_val({12'h000, rsp.write_back, rsp.zero_flag, rsp.half_carry_flag, rsp.carry_flag},
                  {12'h000, e.write_back, e.zero_flag, e.half_carry_flag, e.carry_flag}, "rsp flags");
        check_val({13'h0000, zf, hf, cf}, {13'h0000, e.zero_flag, e.half_carry_flag, e.carry_flag}, "flags");
        if (e.write_back) begin
            check_val(r.op inside {OP_WIDE_SUM, OP_WIDE_MINUS} ? rsp.result : {8'h00, rsp.result[7:0]},
                      e.result, "result");
        end
        ez = e.zero_flag;
        eh = e.half_carry_flag;
        ec = e.carry_flag;
    endtask : run_op

    initial begin
        alu_req_t r;
        void'($urandom(83));
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        check_val({12'h000, ready, zf, hf, cf}, 16'h0008, "reset state");
        run_op(mk(OP_SUM_WITH_CARRY, FORM_REG, 16'h000F, 16'h0001, 3'b000));
        run_op(mk(OP_SUM, FORM_REG, 16'h00FF, 16'h0001, 3'b000));
        run_op(mk(OP_AND, FORM_IND, 16'h00F0, 16'h000F, 3'b110));
        run_op(mk(OP_SUM_WITH_CARRY, FORM_DIR, 16'h0000, 16'h0000, 3'b010));
        run_op(mk(OP_MINUS, FORM_SADDR, 16'h0010, 16'h0001, 3'b000));
        run_op(mk(OP_MINUS, FORM_REG, 16'h0000, 16'h0001, 3'b100));
        run_op(mk(OP_MINUS_BORROW, FORM_IMM, 16'h0001, 16'h0000, 3'b000));
        run_op(mk(OP_OR, FORM_SIMM, 16'h00A0, 16'h0005, 3'b000));
        run_op(mk(OP_XOR, FORM_IND, 16'h005A, 16'h005A, 3'b001));
        run_op(mk(OP_COMPARE, FORM_SIMM, 16'h0005, 16'h0006, 3'b110));
        run_op(mk(OP_ZERO_TEST, FORM_DIR, 16'h0000, 16'h0000, 3'b100));
        run_op(mk(OP_INDEX_COMPARE, FORM_IND, 16'h0030, 16'h0031, 3'b100));
        run_op(mk(OP_WIDE_SUM, FORM_REG, 16'hFFFF, 16'h0001, 3'b000));
        run_op(mk(OP_WIDE_MINUS, FORM_IMM, 16'h1000, 16'h0001, 3'b000));
        for (int i = 0; i < 300; i++) begin
            r = mk(alu_op_t'($urandom_range(0, 11)), form_t'($urandom_range(0, 5)), 16'($urandom),
                   16'($urandom), 3'($urandom));
            if (r.op inside {OP_ZERO_TEST, OP_INDEX_COMPARE} && r.form == FORM_SIMM) begin
                r.form = FORM_REG;
            end
            run_op(r);
        end
        end_of_test();
    end
endmodule : arith_logic_unit_tb
